// ==== verilog/fvr_pkg.sv ====
// Package: command codes, field layout, reset values and timing for fault response
package fvr_pkg;
    // Command codes
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_OV_RESPONSE  = 8'h41;
    localparam logic [7:0] CMD_UV_LIMIT     = 8'h44;
    localparam logic [7:0] CMD_UV_RESPONSE  = 8'h45;
    localparam logic [7:0] CMD_STATUS_VOUT  = 8'h7a;

    // Response byte layout
    localparam int BEHAV_BIT = 7;
    localparam int RETRY_HI  = 5;
    localparam int RETRY_LO  = 3;
    localparam int DELAY_HI  = 2;
    localparam int DELAY_LO  = 0;
    localparam logic [2:0] RETRY_CONTINUOUS = 3'h7;
    localparam logic [7:0] RESPONSE_RESET   = 8'h80;

    // Status byte layout
    localparam int STAT_OV_BIT = 7;
    localparam int STAT_UV_BIT = 4;

    // Threshold default as a fraction of the strap
    localparam logic [20:0] UV_DEFAULT_NUM = 21'h000011;
    localparam logic [20:0] UV_DEFAULT_DEN = 21'h000014;
    localparam logic [15:0] UV_LIMIT_RESET = 16'h0000;

    // Retry time unit
    localparam int CLK_MHZ        = 250;
    localparam int RETRY_UNIT_MS  = 35;
    localparam int RETRY_UNIT_CYC = RETRY_UNIT_MS * CLK_MHZ * 1000;

    typedef enum logic [3:0] {
        ST_OFF   = 4'h1,
        ST_ON    = 4'h2,
        ST_WAIT  = 4'h4,
        ST_LATCH = 4'h8
    } fvr_state_type;
endpackage

// ==== verilog/fvr_tmr_if.sv ====
// Interface between the fault controller and its retry timer
`timescale 1ns/1ps
`default_nettype none
interface fvr_tmr_if;
    logic       run;
    logic       clr;
    logic [3:0] ticks;
    modport ctrl  (output run, output clr, input ticks);
    modport timer (input run, input clr, output ticks);
endinterface
`default_nettype wire

// ==== verilog/fvr_retry_timer.sv ====
// Retry timer: counts whole retry time units while running
`timescale 1ns/1ps
`default_nettype none
module fvr_retry_timer #(
    parameter int UNIT_CYC = fvr_pkg::RETRY_UNIT_CYC,
    parameter int PRE_W    = 24
) (
    // Clock, reset and enable
    input  wire logic  mclk,
    input  wire logic  nrst,
    input  wire logic  ce,
    // Controller side
    fvr_tmr_if.timer   tmr
);
    logic [PRE_W-1:0] pre_reg;
    logic [PRE_W-1:0] pre_next;
    logic [3:0]       ticks_reg;
    logic [3:0]       ticks_next;

    always_comb begin
        pre_next   = pre_reg;
        ticks_next = ticks_reg;
        if (tmr.clr) begin
            pre_next   = '0;
            ticks_next = 4'h0;
        end else if (tmr.run) begin
            if (pre_reg == PRE_W'(UNIT_CYC - 1)) begin
                pre_next = '0;
                // Saturate: longest delay needs only eight units
                if (ticks_reg != 4'hf) begin
                    ticks_next = ticks_reg + 4'h1;
                end
            end else begin
                pre_next = pre_reg + PRE_W'(1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pre_reg   <= '0;
            ticks_reg <= 4'h0;
        end else if (ce) begin
            pre_reg   <= pre_next;
            ticks_reg <= ticks_next;
        end
    end

    assign tmr.ticks = ticks_reg;
endmodule
`default_nettype wire

// ==== verilog/fvr_vout_fault.sv ====
// Output voltage fault supervision: limits, responses, status and retry control
//
// Functional notes
// - Behavior 1x disables output, then retry field
// - Fault pulls alert low, sets status
// - Status bits clear only by clear-faults
// - Retry 000 keeps output off until restart
// - Retry 111 restarts until off or fault
// - Retry delay is (field+1) times 35 ms
// - Delay measured start to start of attempts
// - Threshold 16-bit unsigned, 2^-13 volt steps
// - Undervoltage masked before power-good or disabled
// - Threshold defaults to 0.85 of strap
// - Undervoltage response resets to 80h
// - Undervoltage response is one paged byte
// - Overvoltage response same layout, resets 80h
`timescale 1ns/1ps
`default_nettype none
module fvr_vout_fault #(
    parameter int RETRY_UNIT_CYC = fvr_pkg::RETRY_UNIT_CYC
) (
    // Clock, reset, enable
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        ce,
    // Decoded command port
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    output logic      [15:0] cmd_rdata,
    // Converter state
    input  wire logic [15:0] vout_meas,
    input  wire logic [15:0] voltage_setpoint_strap,
    input  wire logic        output_good_flag,
    input  wire logic        ov_detect,
    input  wire logic        enable_cmd,
    input  wire logic        bias_ok,
    input  wire logic        other_fault,
    // Output control and alert
    output logic             out_enable,
    output logic             alert_line_o,
    output logic             alert_line_oe_n
);
    fvr_tmr_if tmr ();

    fvr_retry_timer #(
        .UNIT_CYC (RETRY_UNIT_CYC),
        .PRE_W    (24)
    ) u_timer (
        .mclk (mclk),
        .nrst (nrst),
        .ce   (ce),
        .tmr  (tmr)
    );

    function automatic logic [2:0] retry_of(input logic [7:0] resp);
        retry_of = resp[fvr_pkg::RETRY_HI:fvr_pkg::RETRY_LO];
    endfunction

    function automatic logic [3:0] wait_units(input logic [7:0] resp);
        wait_units = {1'b0, resp[fvr_pkg::DELAY_HI:fvr_pkg::DELAY_LO]} + 4'h1;
    endfunction

    fvr_pkg::fvr_state_type state_reg;
    fvr_pkg::fvr_state_type state_next;
    logic [15:0] uv_limit_reg;
    logic [15:0] uv_limit_next;
    logic [7:0]  uv_resp_reg;
    logic [7:0]  uv_resp_next;
    logic [7:0]  ov_resp_reg;
    logic [7:0]  ov_resp_next;
    logic [7:0]  act_resp_reg;
    logic [7:0]  act_resp_next;
    logic        strap_done_reg;
    logic        strap_done_next;
    logic        uv_stat_reg;
    logic        uv_stat_next;
    logic        ov_stat_reg;
    logic        ov_stat_next;
    logic        out_en_reg;
    logic        out_en_next;
    logic        alert_oe_n_reg;
    logic        alert_oe_n_next;
    logic        run_reg;
    logic        run_next;
    logic        clr_reg;
    logic        clr_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;

    logic        start_ok;
    logic        wr_hit;
    logic        clear_hit;
    logic        uv_event;
    logic        ov_event;
    logic [7:0]  fault_resp;
    logic [20:0] strap_scaled;
    logic [7:0]  status_byte;

    assign start_ok  = enable_cmd && bias_ok && !other_fault;
    assign wr_hit    = cmd_valid && cmd_write;
    assign clear_hit = wr_hit && (cmd_code == fvr_pkg::CMD_CLEAR_FAULTS);
    // Undervoltage only counts once regulating and good
    assign uv_event  = (state_reg == fvr_pkg::ST_ON) && output_good_flag
                       && (vout_meas < uv_limit_reg);
    assign ov_event  = (state_reg == fvr_pkg::ST_ON) && ov_detect;
    // Overvoltage takes priority when both strike together
    assign fault_resp = ov_event ? ov_resp_reg : uv_resp_reg;
    assign strap_scaled = (21'(voltage_setpoint_strap) * fvr_pkg::UV_DEFAULT_NUM)
                          / fvr_pkg::UV_DEFAULT_DEN;
    assign status_byte = 8'(({7'h00, ov_stat_reg} << fvr_pkg::STAT_OV_BIT)
                       | ({7'h00, uv_stat_reg} << fvr_pkg::STAT_UV_BIT));

    // Register file and sticky status
    always_comb begin
        uv_limit_next   = uv_limit_reg;
        uv_resp_next    = uv_resp_reg;
        ov_resp_next    = ov_resp_reg;
        strap_done_next = 1'b1;
        rdata_next      = rdata_reg;
        // Strap is sampled once, on the first cycle after reset
        if (!strap_done_reg) begin
            uv_limit_next = strap_scaled[15:0];
        end else if (wr_hit) begin
            case (cmd_code)
                fvr_pkg::CMD_UV_LIMIT:    uv_limit_next = cmd_wdata;
                fvr_pkg::CMD_UV_RESPONSE: uv_resp_next  = cmd_wdata[7:0];
                fvr_pkg::CMD_OV_RESPONSE: ov_resp_next  = cmd_wdata[7:0];
                default:                  uv_limit_next = uv_limit_reg;
            endcase
        end
        if (cmd_valid && !cmd_write) begin
            case (cmd_code)
                fvr_pkg::CMD_UV_LIMIT:    rdata_next = uv_limit_reg;
                fvr_pkg::CMD_UV_RESPONSE: rdata_next = {8'h00, uv_resp_reg};
                fvr_pkg::CMD_OV_RESPONSE: rdata_next = {8'h00, ov_resp_reg};
                fvr_pkg::CMD_STATUS_VOUT: rdata_next = {8'h00, status_byte};
                default:                  rdata_next = 16'h0000;
            endcase
        end
        // New fault wins over a simultaneous clear
        uv_stat_next    = uv_event || (uv_stat_reg && !clear_hit);
        ov_stat_next    = ov_event || (ov_stat_reg && !clear_hit);
        alert_oe_n_next = !(uv_stat_next || ov_stat_next);
    end

    // Output state machine
    always_comb begin
        state_next    = state_reg;
        act_resp_next = act_resp_reg;
        clr_next      = 1'b0;
        case (state_reg)
            fvr_pkg::ST_OFF: begin
                if (start_ok) begin
                    state_next = fvr_pkg::ST_ON;
                    clr_next   = 1'b1;
                end
            end
            fvr_pkg::ST_ON: begin
                if (!start_ok) begin
                    state_next = fvr_pkg::ST_OFF;
                end else if (uv_event || ov_event) begin
                    act_resp_next = fault_resp;
                    // Codes 00 and 01 are unused: flag only, stay on
                    if (fault_resp[fvr_pkg::BEHAV_BIT]) begin
                        if (retry_of(fault_resp) == fvr_pkg::RETRY_CONTINUOUS) begin
                            state_next = fvr_pkg::ST_WAIT;
                        end else begin
                            state_next = fvr_pkg::ST_LATCH;
                        end
                    end
                end
            end
            fvr_pkg::ST_WAIT: begin
                if (!start_ok) begin
                    state_next = fvr_pkg::ST_OFF;
                end else if (tmr.ticks >= wait_units(act_resp_reg)) begin
                    state_next = fvr_pkg::ST_ON;
                    clr_next   = 1'b1;
                end
            end
            fvr_pkg::ST_LATCH: begin
                // Only a restart releases the latched shutdown
                if (!enable_cmd || !bias_ok) begin
                    state_next = fvr_pkg::ST_OFF;
                end
            end
            default: state_next = fvr_pkg::ST_OFF;
        endcase
        out_en_next = (state_next == fvr_pkg::ST_ON);
        run_next    = (state_next == fvr_pkg::ST_ON)
                      || (state_next == fvr_pkg::ST_WAIT);
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_reg      <= fvr_pkg::ST_OFF;
            uv_limit_reg   <= fvr_pkg::UV_LIMIT_RESET;
            uv_resp_reg    <= fvr_pkg::RESPONSE_RESET;
            ov_resp_reg    <= fvr_pkg::RESPONSE_RESET;
            act_resp_reg   <= fvr_pkg::RESPONSE_RESET;
            strap_done_reg <= 1'b0;
            uv_stat_reg    <= 1'b0;
            ov_stat_reg    <= 1'b0;
            out_en_reg     <= 1'b0;
            alert_oe_n_reg <= 1'b1;
            run_reg        <= 1'b0;
            clr_reg        <= 1'b0;
            rdata_reg      <= 16'h0000;
        end else if (ce) begin
            state_reg      <= state_next;
            uv_limit_reg   <= uv_limit_next;
            uv_resp_reg    <= uv_resp_next;
            ov_resp_reg    <= ov_resp_next;
            act_resp_reg   <= act_resp_next;
            strap_done_reg <= strap_done_next;
            uv_stat_reg    <= uv_stat_next;
            ov_stat_reg    <= ov_stat_next;
            out_en_reg     <= out_en_next;
            alert_oe_n_reg <= alert_oe_n_next;
            run_reg        <= run_next;
            clr_reg        <= clr_next;
            rdata_reg      <= rdata_next;
        end
    end

    // Open-drain alert: the pin only ever drives low
    always_ff @(posedge mclk) begin
        alert_line_o <= 1'b0;
    end

    assign tmr.run         = run_reg;
    assign tmr.clr         = clr_reg;
    assign out_enable      = out_en_reg;
    assign alert_line_oe_n = alert_oe_n_reg;
    assign cmd_rdata       = rdata_reg;

    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence fault_disable_seq;
        ce && state_reg == fvr_pkg::ST_ON && start_ok && (uv_event || ov_event)
        && fault_resp[fvr_pkg::BEHAV_BIT];
    endsequence

    sequence restart_due_seq;
        ce && state_reg == fvr_pkg::ST_WAIT && start_ok
        && tmr.ticks >= wait_units(act_resp_reg);
    endsequence

    a_fault_disables: assert property (
        fault_disable_seq |=> !out_enable)
        else $error("Output not disabled after fault");
    a_alert_follows: assert property (
        (uv_stat_reg || ov_stat_reg) |-> !alert_line_oe_n)
        else $error("Alert not driven while fault status set");
    a_status_sticky: assert property (
        uv_stat_reg && !(ce && clear_hit) |=> uv_stat_reg)
        else $error("Undervoltage status cleared without command");
    a_latch_holds: assert property (
        state_reg == fvr_pkg::ST_LATCH && enable_cmd && bias_ok
        |=> state_reg == fvr_pkg::ST_LATCH)
        else $error("Latched shutdown left without restart");
    a_retry_stops: assert property (
        ce && state_reg == fvr_pkg::ST_WAIT && !enable_cmd
        |=> state_reg == fvr_pkg::ST_OFF && !out_enable)
        else $error("Retry continued after command off");
    a_retry_early: assert property (
        state_reg == fvr_pkg::ST_WAIT && tmr.ticks < wait_units(act_resp_reg)
        |=> state_reg != fvr_pkg::ST_ON)
        else $error("Restart before retry delay");
    a_retry_ontime: assert property (
        restart_due_seq |=> out_enable ##1 tmr.ticks == 4'h0 || !ce)
        else $error("Restart not taken when delay expired");
    a_uv_masked: assert property (
        $rose(uv_stat_reg) |-> $past(state_reg) == fvr_pkg::ST_ON && $past(output_good_flag))
        else $error("Undervoltage flagged while masked");
    a_strap_default: assert property (
        $rose(strap_done_reg)
        |-> uv_limit_reg == 16'((21'($past(voltage_setpoint_strap))
            * fvr_pkg::UV_DEFAULT_NUM) / fvr_pkg::UV_DEFAULT_DEN))
        else $error("Threshold default not taken from strap");
    a_resp_reset: assert property (
        !$past(nrst) |-> uv_resp_reg == fvr_pkg::RESPONSE_RESET
        && ov_resp_reg == fvr_pkg::RESPONSE_RESET)
        else $error("Response registers not at reset value");
    a_timer_stop: assert property (
        ce && state_reg == fvr_pkg::ST_OFF && $past(state_reg) == fvr_pkg::ST_OFF
        |=> $stable(tmr.ticks))
        else $error("Retry timer ran while commanded off");
    // Reverse direction of the alert check: a clean clear releases the pin
    a_alert_release: assert property (
        ce && clear_hit && !uv_event && !ov_event |=> alert_line_oe_n)
        else $error("Alert held after clear-faults");
    a_uv_sets_status: assert property (
        ce && uv_event |=> uv_stat_reg && !alert_line_oe_n)
        else $error("Undervoltage fault not latched");
    a_no_retry_latch: assert property (
        fault_disable_seq ##0 retry_of(fault_resp) != fvr_pkg::RETRY_CONTINUOUS
        |=> state_reg == fvr_pkg::ST_LATCH)
        else $error("Non-continuous retry code did not latch off");
    a_ov_priority: assert property (
        fault_disable_seq ##0 ov_event |=> act_resp_reg == $past(ov_resp_reg))
        else $error("Overvoltage response not applied");
endmodule
`default_nettype wire

// ==== sim/fvr_host_model.sv ====
// Host controller model driving the decoded command port
`timescale 1ns/1ps
`default_nettype none
module fvr_host_model (
    // Clock
    input  wire logic        mclk,
    // Command port
    output logic             cmd_valid,
    output logic             cmd_write,
    output logic [7:0]       cmd_code,
    output logic [15:0]      cmd_wdata,
    input  wire logic [15:0] cmd_rdata
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
    end

    // Idle code and data lines invert so a stale code never looks valid
    task automatic send(input logic w, input logic [7:0] c,
                        input logic [15:0] d, output logic [15:0] r);
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_code  <= c;
        cmd_wdata <= d;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        cmd_code  <= ~c;
        cmd_wdata <= ~d;
        #1;
        r = cmd_rdata;
    endtask
endmodule
`default_nettype wire

// ==== sim/fvr_vout_fault_tb.sv ====
// Testbench: register access, fault responses and retry timing
`timescale 1ns/1ps
`default_nettype none
module fvr_vout_fault_tb;
    localparam int U = 10;
    logic        mclk, nrst, ce, good, ov, en, bias, oth;
    logic        cmd_valid, cmd_write, out_enable, al_o, al_oe_n;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata, vout, strap, q;
    int          fails, num_checks, seed, n, d, e;
    // Reference model of the register map, indexed by command code
    int          mreg [256];

    fvr_vout_fault #(.RETRY_UNIT_CYC(U)) dut (
        .mclk(mclk), .nrst(nrst), .ce(ce), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .cmd_rdata(cmd_rdata), .vout_meas(vout), .voltage_setpoint_strap(strap),
        .output_good_flag(good), .ov_detect(ov), .enable_cmd(en), .bias_ok(bias),
        .other_fault(oth), .out_enable(out_enable), .alert_line_o(al_o),
        .alert_line_oe_n(al_oe_n)
    );
    fvr_host_model host (
        .mclk(mclk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata)
    );

    always #2 mclk = ~mclk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic model_reset();
        foreach (mreg[k]) begin
            mreg[k] = 0;
        end
        mreg['h41] = 'h80;
        mreg['h45] = 'h80;
        mreg['h44] = (int'(strap) * 17) / 20;
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] v);
        host.send(1'b1, c, v, q);
        // Clock enable low: the command is dropped
        if (ce === 1'b1) begin
            case (c)
                8'h44: mreg[c] = int'(v);
                8'h41, 8'h45: mreg[c] = int'(v[7:0]);
                8'h03: mreg['h7a] = 0;
                default: ;
            endcase
        end
    endtask
    task automatic rchk(input logic [7:0] c, input logic [15:0] exp, input string m);
        host.send(1'b0, c, 16'h0000, q);
        chk(q, exp, m);
        chk(q, 16'(mreg[c]), m);
    endtask
    task automatic pins(input logic [2:0] exp, input string m);
        chk({13'h0, out_enable, al_o, al_oe_n}, {13'h0, exp}, m);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic lvl(input logic v);
        while (out_enable !== v && n < 400) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (out_enable !== v) begin
            fails++;
            $display("FAIL t=%0t output level wait expired", $time);
        end
    endtask
    task automatic restart();
        @(posedge mclk);
        en <= 1'b0;
        cyc(2);
        @(posedge mclk);
        en <= 1'b1;
        cyc(3);
        wr(8'h03, 16'h0000);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #200000;
        fails++;
        $display("FAIL t=%0t watchdog expired", $time);
        final_report();
    end

    initial begin
        mclk = 1'b0;
        nrst = 1'b0;
        ce = 1'b1;
        good = 1'b0;
        ov = 1'b0;
        en = 1'b0;
        bias = 1'b1;
        oth = 1'b0;
        fails = 0;
        num_checks = 0;
        seed = 92707;
        vout = 16'h3000;
        strap = 16'($random(seed));
        model_reset();
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        cyc(3);
        rchk(8'h45, 16'h0080, "uv resp reset");
        rchk(8'h41, 16'h0080, "ov resp reset");
        e = (int'(strap) * 17) / 20;
        rchk(8'h44, 16'(e), "limit default");
        rchk(8'h5a, 16'h0000, "unmapped read");
        rchk(8'h7a, 16'h0000, "status reset");
        pins(3'b001, "pins reset");
        done("defaults");
        for (int i = 0; i < 3; i++) begin
            d = (i == 0) ? 'hffff : $random(seed);
            wr(8'h44, 16'(d));
            rchk(8'h44, 16'(d), "limit rw");
            wr(8'h41, 16'(d));
            rchk(8'h41, {8'h00, 8'(d)}, "ov resp rw");
        end
        // Mid-run reset must restore the overvoltage response and reload the strap default
        @(posedge mclk);
        nrst <= 1'b0;
        cyc(2);
        @(posedge mclk);
        nrst <= 1'b1;
        cyc(3);
        model_reset();
        rchk(8'h41, 16'h0080, "ov resp re-reset");
        rchk(8'h44, 16'(e), "limit reload");
        wr(8'h45, 16'h0080);
        wr(8'h44, 16'h2000);
        @(posedge mclk);
        ce <= 1'b0;
        wr(8'h45, 16'h00ff);
        @(posedge mclk);
        ce <= 1'b1;
        rchk(8'h45, 16'h0080, "ce freeze");
        done("read-back");
        @(posedge mclk);
        vout <= 16'h1000;
        en <= 1'b1;
        cyc(3);
        pins(3'b101, "start");
        cyc(5);
        pins(3'b101, "uv masked");
        rchk(8'h7a, 16'h0000, "no uv status");
        @(posedge mclk);
        good <= 1'b1;
        cyc(3);
        pins(3'b000, "uv shutdown");
        mreg['h7a] = mreg['h7a] | 'h10;
        @(posedge mclk);
        vout <= 16'h3000;
        cyc(20);
        pins(3'b000, "stays off");
        rchk(8'h7a, 16'h0010, "uv status held");
        wr(8'h03, 16'h0000);
        rchk(8'h7a, 16'h0000, "status cleared");
        pins(3'b001, "alert released");
        done("undervoltage");
        for (int b = 0; b < 4; b++) begin
            // Retry codes 000 to 011 with behavior 00 to 11: behavior 0x stays on, 1x latches off
            wr(8'h41, {8'h00, 2'(b), 3'(b), 3'h0});
            restart();
            @(posedge mclk);
            ov <= 1'b1;
            cyc(3);
            pins({~b[1], 2'b00}, "ov response");
            mreg['h7a] = mreg['h7a] | 'h80;
            @(posedge mclk);
            ov <= 1'b0;
            cyc(5);
            rchk(8'h7a, 16'h0080, "ov status");
            pins({~b[1], 2'b00}, "ov after removal");
        end
        done("overvoltage");
        for (int i = 0; i < 3; i++) begin
            d = (i == 0) ? 0 : (i == 1) ? 7 : ($random(seed) & 7);
            wr(8'h45, {8'h00, 5'h17, 3'(d)});
            restart();
            @(posedge mclk);
            vout <= 16'h1000;
            n = 0;
            lvl(1'b0);
            lvl(1'b1);
            n = 0;
            lvl(1'b0);
            lvl(1'b1);
            e = (d + 1) * U;
            chk(16'(n >= e - 2 && n <= e + 2), 16'h0001, "retry period");
            // Each pass stops the retries by a different cause
            @(posedge mclk);
            case (i)
                0: oth <= 1'b1;
                1: bias <= 1'b0;
                default: en <= 1'b0;
            endcase
            vout <= 16'h3000;
            cyc(e + 20);
            pins(3'b000, "retry stopped");
            @(posedge mclk);
            oth <= 1'b0;
            bias <= 1'b1;
            en <= 1'b1;
        end
        done("retry");
        final_report();
    end
endmodule
`default_nettype wire
